// File: hw/ast_pkg.sv
// Constants, register map and state types of the async serial transceiver
// Function
// - Word length selects 8 or 9 bits
// - Start bit low, stop bit high
// - Idle is 10 or 11 high bits
// - Ninth transmit bit comes from tx_ninth_bit
// - LSB first through tx_holding_buf
// - Enabling transmitter sends idle preamble first
// - Status access then data write clears flags
// - Busy write waits in holding buffer
// - Idle write loads shifter, sets empty flag
// - Done flag after stop or break
// - Breaks repeat, then one trailing one
// - Transmitter toggle: preamble, holding data lost
// - Received ninth bit goes to rx_ninth_bit
// - Receiver hunts start bit, LSB first
// - Completed character fills buffer, sets full
// - Status access then data read clears
// - Idle line sets flag and interrupts
// - Overrun keeps buffer, sets overrun flag
// - Noise flag rises with full flag
// - Missing stop or break sets framing
// - Idle enabled pin high, disabled released
package ast_pkg;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_CTRL1  = 8'h08;
  localparam logic [7:0] OFF_CTRL2  = 8'h0C;
  localparam logic [7:0] OFF_BAUD   = 8'h10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ctrl_one fields
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_M   = 4;
  // ctrl_two fields
  localparam int C2_TIE  = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_IDLE_IRQ_EN = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_SBK  = 0;
  // baud_reg fields
  localparam int BR_PRE_HI = 7;
  localparam int BR_PRE_LO = 6;
  localparam int BR_TX_HI  = 5;
  localparam int BR_TX_LO  = 3;
  localparam int BR_RX_HI  = 2;
  localparam int BR_RX_LO  = 0;
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  // Prescaler values selected by baud_prediv_sel 0..3
  localparam logic [3:0] PRE_1  = 4'h1;
  localparam logic [3:0] PRE_3  = 4'h3;
  localparam logic [3:0] PRE_4  = 4'h4;
  localparam logic [3:0] PRE_13 = 4'hD;
  // Oversampling: 16 ticks per bit, votes on ticks 7..9
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] SAMP_A    = 4'h7;
  localparam logic [3:0] SAMP_C    = 4'h9;
  localparam logic [3:0] SAMP_EVAL = 4'hA;
  // Frame lengths in bits, data bits, idle length in ticks minus one
  localparam logic [3:0] LEN8   = 4'hA;
  localparam logic [3:0] LEN9   = 4'hB;
  localparam logic [3:0] DBITS8 = 4'h8;
  localparam logic [3:0] DBITS9 = 4'h9;
  localparam logic [7:0] IDLE8  = 8'h9F;
  localparam logic [7:0] IDLE9  = 8'hAF;

  typedef enum logic [5:0] {
    TX_OFF   = 6'b000001,
    TX_PRE   = 6'b000010,
    TX_IDLE  = 6'b000100,
    TX_SHIFT = 6'b001000,
    TX_BRK   = 6'b010000,
    TX_TAIL  = 6'b100000
  } ast_tx_st_t;

  typedef enum logic [3:0] {
    RX_OFF   = 4'b0001,
    RX_WAIT  = 4'b0010,
    RX_HUNT  = 4'b0100,
    RX_FRAME = 4'b1000
  } ast_rx_st_t;
endpackage

// File: hw/ast_baud_tick.sv
// Oversampling tick generator: one pulse per clock/(prescale*2^div)
`timescale 1ns/1ps
`default_nettype none
module ast_baud_tick
  import ast_pkg::*;
#(
  parameter int CNT_W = 11
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             run_i,
  input  wire logic [1:0]       pre_sel_i,
  input  wire logic [2:0]       div_sel_i,
  output logic                  tick_o
);
  generate
    if (CNT_W < 11) begin : g_chk
      $error("ast_baud_tick: CNT_W too small for 13*128");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] lim;
  logic [3:0]       pre;

  always_comb begin
    unique case (pre_sel_i)
      2'h0: pre = PRE_1;
      2'h1: pre = PRE_3;
      2'h2: pre = PRE_4;
      2'h3: pre = PRE_13;
    endcase
    lim = CNT_W'((CNT_W'(pre) << div_sel_i) - CNT_W'(1));
  end

  // Counter restarts only while run_i is low (direction disabled), not between frames
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + CNT_W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: hw/ast_vote.sv
// Two-of-three majority vote with disagreement flag
`timescale 1ns/1ps
`default_nettype none
module ast_vote (
  input  wire logic [2:0] samp_i,
  output logic            bit_o,
  output logic            noise_o
);
  always_comb begin
    bit_o   = (samp_i[0] & samp_i[1]) | (samp_i[1] & samp_i[2]) | (samp_i[0] & samp_i[2]);
    noise_o = !(&samp_i) && (|samp_i);
  end
endmodule
`default_nettype wire

// File: hw/ast_top.sv
// Async serial transceiver: AHB-Lite registers, transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module ast_top
  import ast_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        rx_i,
  input  wire logic        irq_unmask_i,
  output logic             tx_o,
  output logic             tx_oe_o,
  output logic             irq_o
);
  // Control and status state
  logic       m_r, tx9_r, tie_r, tx_done_irq_en_r, rie_r, idle_irq_en_r, txon_r, rxon_r, sbk_r;
  logic [7:0] baud_r;
  logic       tx_buf_empty_flag_r, tc_r, rx_buf_full_flag_r, idle_r, ovr_r, nf_r, fe_r, rx9_r;
  logic [7:0] rxbuf_r;
  logic       stat_seen_r;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;

  // Bus decode: zero wait states, reads sampled at the address phase
  logic addr_ph, rd_ev, rd_status, rd_data, we_data, we_ctrl1, we_ctrl2, we_baud;
  assign addr_ph   = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);
  assign rd_ev     = addr_ph && !hwrite_i;
  assign rd_status = rd_ev && (haddr_i[7:0] == OFF_STATUS);
  assign rd_data   = rd_ev && (haddr_i[7:0] == OFF_DATA);
  assign we_data   = wr_pend_r && (wr_addr_r == OFF_DATA);
  assign we_ctrl1  = wr_pend_r && (wr_addr_r == OFF_CTRL1);
  assign we_ctrl2  = wr_pend_r && (wr_addr_r == OFF_CTRL2);
  assign we_baud   = wr_pend_r && (wr_addr_r == OFF_BAUD);

  logic tx_clr, rx_clr;
  assign tx_clr = we_data && stat_seen_r;
  assign rx_clr = rd_data && stat_seen_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_r   <= addr_ph && hwrite_i;
      wr_addr_r   <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= '0;
    end else if (rd_ev) begin
      unique case (haddr_i[7:0])
        OFF_STATUS: hrdata_o <= {24'h000000, tx_buf_empty_flag_r, tc_r, rx_buf_full_flag_r, idle_r, ovr_r, nf_r, fe_r, 1'b0};
        OFF_DATA:   hrdata_o <= {24'h000000, rxbuf_r};
        OFF_CTRL1:  hrdata_o <= {24'h000000, rx9_r, tx9_r, 1'b0, m_r, 4'h0};
        OFF_CTRL2:  hrdata_o <= {24'h000000, tie_r, tx_done_irq_en_r, rie_r, idle_irq_en_r, txon_r, rxon_r, 1'b0, sbk_r};
        OFF_BAUD:   hrdata_o <= {24'h000000, baud_r};
        default:    hrdata_o <= '0;
      endcase
    end
  end

  // A status read arms the clearing sequence, any data access consumes it
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_seen_r <= 1'b0;
    end else if (rd_status) begin
      stat_seen_r <= 1'b1;
    end else if (rd_data || we_data) begin
      stat_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {m_r, tx9_r} <= 2'b00;
      {tie_r, tx_done_irq_en_r, rie_r, idle_irq_en_r, txon_r, rxon_r, sbk_r} <= 7'h00;
      baud_r <= BAUD_RST;
    end else begin
      if (we_ctrl1) begin
        m_r   <= hwdata_i[C1_M];
        tx9_r <= hwdata_i[C1_TX9];
      end
      if (we_ctrl2) begin
        tie_r  <= hwdata_i[C2_TIE];
        tx_done_irq_en_r <= hwdata_i[C2_TX_DONE_IRQ_EN];
        rie_r  <= hwdata_i[C2_RIE];
        idle_irq_en_r <= hwdata_i[C2_IDLE_IRQ_EN];
        txon_r <= hwdata_i[C2_TE];
        rxon_r <= hwdata_i[C2_RE];
        sbk_r  <= hwdata_i[C2_SBK];
      end
      // Changing the rate while running garbles the frame in flight
      if (we_baud) begin
        baud_r <= hwdata_i[7:0];
      end
    end
  end

  logic [3:0] frame_len;
  assign frame_len = m_r ? LEN9 : LEN8;

  // Transmitter
  ast_tx_st_t  tx_st;
  logic [10:0] tx_sh_r;
  logic [8:0]  txbuf_r;
  logic        hold_v_r, pre_pend_r, txon_q_r;
  logic [3:0]  tx_sub_r, tx_bits_r;
  logic        tx_tick, tx_bit_end, tx_last;
  logic        tx_run;

  assign tx_run     = txon_r || (tx_st != TX_OFF);
  assign tx_bit_end = tx_tick && (tx_sub_r == OVS_LAST);
  assign tx_last    = tx_bit_end && (tx_bits_r == 4'h1);

  ast_baud_tick #(.CNT_W(11)) u_tx_baud (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .run_i     (tx_run),
    .pre_sel_i (baud_r[BR_PRE_HI:BR_PRE_LO]),
    .div_sel_i (baud_r[BR_TX_HI:BR_TX_LO]),
    .tick_o    (tx_tick)
  );

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_sub_r <= '0;
    end else if (tx_st == TX_OFF || tx_st == TX_IDLE) begin
      tx_sub_r <= '0;
    end else if (tx_tick) begin
      tx_sub_r <= tx_sub_r + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st      <= TX_OFF;
      tx_sh_r    <= '1;
      tx_bits_r  <= '0;
      txbuf_r    <= '0;
      hold_v_r   <= 1'b0;
      pre_pend_r <= 1'b0;
      txon_q_r   <= 1'b0;
      tx_buf_empty_flag_r     <= STATUS_RST[7];
      tc_r       <= STATUS_RST[6];
    end else begin
      txon_q_r <= txon_r;
      if (tx_clr) begin
        tx_buf_empty_flag_r <= 1'b0;
        tc_r   <= 1'b0;
      end
      if (txon_q_r && !txon_r) begin
        pre_pend_r <= 1'b1;
        hold_v_r   <= 1'b0;
      end
      unique case (tx_st)
        TX_OFF: begin
          if (txon_r) begin
            tx_st      <= TX_PRE;
            tx_bits_r  <= frame_len;
            pre_pend_r <= 1'b0;
          end
        end
        TX_PRE: begin
          if (tx_bit_end) begin
            tx_bits_r <= tx_bits_r - 4'h1;
          end
          if (tx_last) begin
            tx_st <= txon_r ? TX_IDLE : TX_OFF;
          end
        end
        TX_IDLE: begin
          if (!txon_r) begin
            tx_st <= TX_OFF;
          end else if (sbk_r) begin
            tx_st     <= TX_BRK;
            tx_bits_r <= frame_len;
          end else if (hold_v_r) begin
            tx_st     <= TX_SHIFT;
            tx_sh_r   <= m_r ? {1'b1, txbuf_r, 1'b0} : {2'b11, txbuf_r[7:0], 1'b0};
            tx_bits_r <= frame_len;
            hold_v_r  <= 1'b0;
            tx_buf_empty_flag_r    <= 1'b1;
          end
        end
        TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
          end
          if (tx_last) begin
            if (!txon_r) begin
              tx_st <= TX_OFF;
              tc_r  <= 1'b1;
            end else if (pre_pend_r) begin
              tx_st      <= TX_PRE;
              tx_bits_r  <= frame_len;
              pre_pend_r <= 1'b0;
              tc_r       <= 1'b1;
            end else if (hold_v_r && !sbk_r) begin
              tx_sh_r   <= m_r ? {1'b1, txbuf_r, 1'b0} : {2'b11, txbuf_r[7:0], 1'b0};
              tx_bits_r <= frame_len;
              hold_v_r  <= 1'b0;
              tx_buf_empty_flag_r    <= 1'b1;
            end else begin
              tx_st <= TX_IDLE;
              tc_r  <= 1'b1;
            end
          end
        end
        TX_BRK: begin
          if (tx_bit_end) begin
            tx_bits_r <= tx_bits_r - 4'h1;
          end
          if (tx_last) begin
            tc_r <= 1'b1;
            if (sbk_r) begin
              tx_bits_r <= frame_len;
            end else begin
              tx_st     <= TX_TAIL;
              tx_bits_r <= 4'h1;
            end
          end
        end
        TX_TAIL: begin
          if (tx_last) begin
            tx_st <= txon_r ? TX_IDLE : TX_OFF;
          end
        end
      endcase
      // Placed last so a write in the cycle of a load is kept, not lost
      if (we_data) begin
        txbuf_r  <= {tx9_r, hwdata_i[7:0]};
        hold_v_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_o    <= 1'b1;
      tx_oe_o <= 1'b0;
    end else begin
      tx_o    <= (tx_st == TX_SHIFT) ? tx_sh_r[0] : (tx_st != TX_BRK);
      tx_oe_o <= (tx_st != TX_OFF);
    end
  end

  // Receiver
  ast_rx_st_t rx_st;
  logic [3:0] rx_sub_r, rx_bitn_r;
  logic [2:0] samp_r;
  logic [8:0] rx_sh_r;
  logic       nacc_r, idle_arm_r;
  logic [7:0] idle_cnt_r;
  logic       rx_tick, v_bit, v_noise, rx_eval, rx_stop, rx_done;
  logic [3:0] dbits;

  assign dbits   = m_r ? DBITS9 : DBITS8;
  assign rx_eval = rx_tick && (rx_st == RX_FRAME) && (rx_sub_r == SAMP_EVAL);
  assign rx_stop = rx_eval && (rx_bitn_r == dbits + 4'h1);
  assign rx_done = rx_stop && rxon_r;

  ast_baud_tick #(.CNT_W(11)) u_rx_baud (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .run_i     (rxon_r),
    .pre_sel_i (baud_r[BR_PRE_HI:BR_PRE_LO]),
    .div_sel_i (baud_r[BR_RX_HI:BR_RX_LO]),
    .tick_o    (rx_tick)
  );

  ast_vote u_vote (
    .samp_i  (samp_r),
    .bit_o   (v_bit),
    .noise_o (v_noise)
  );

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st      <= RX_OFF;
      rx_sub_r   <= '0;
      rx_bitn_r  <= '0;
      samp_r     <= '0;
      rx_sh_r    <= '0;
      nacc_r     <= 1'b0;
    end else if (!rxon_r) begin
      rx_st <= RX_OFF;
    end else if (rx_tick) begin
      unique case (rx_st)
        RX_OFF:  rx_st <= RX_WAIT;
        // After a framing error the line must return high before a new start
        RX_WAIT: if (rx_i) rx_st <= RX_HUNT;
        RX_HUNT: begin
          if (!rx_i) begin
            rx_st     <= RX_FRAME;
            rx_sub_r  <= 4'h1;
            rx_bitn_r <= '0;
            nacc_r    <= 1'b0;
          end
        end
        RX_FRAME: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r >= SAMP_A && rx_sub_r <= SAMP_C) begin
            samp_r <= {samp_r[1:0], rx_i};
          end
          if (rx_sub_r == SAMP_EVAL) begin
            nacc_r    <= nacc_r | v_noise;
            rx_bitn_r <= rx_bitn_r + 4'h1;
            if (rx_bitn_r == 4'h0 && v_bit) begin
              rx_st <= RX_HUNT;              // false start
            end else if (rx_bitn_r != 4'h0 && rx_bitn_r <= dbits) begin
              rx_sh_r[4'(rx_bitn_r - 4'h1)] <= v_bit;
            end else if (rx_bitn_r == dbits + 4'h1) begin
              rx_st <= v_bit ? RX_HUNT : RX_WAIT;
            end
          end
        end
        default: rx_st <= RX_OFF;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt_r <= '0;
      idle_arm_r <= 1'b0;
    end else if (rx_done) begin
      idle_arm_r <= 1'b1;
      idle_cnt_r <= '0;
    end else if (rx_st != RX_HUNT || !rx_i) begin
      idle_cnt_r <= '0;
    end else if (rx_tick && idle_cnt_r != (m_r ? IDLE9 : IDLE8)) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end else if (rx_tick && idle_arm_r) begin
      idle_arm_r <= 1'b0;
    end
  end

  logic idle_hit;
  assign idle_hit = rx_tick && idle_arm_r && (rx_st == RX_HUNT) && rx_i && rx_done == 1'b0
                    && (idle_cnt_r == (m_r ? IDLE9 : IDLE8));

  // Receive flags: set wins over the clearing read in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {rx_buf_full_flag_r, idle_r, ovr_r, nf_r, fe_r} <= STATUS_RST[5:1];
      rxbuf_r <= '0;
      rx9_r   <= 1'b0;
    end else begin
      if (rx_clr) begin
        {rx_buf_full_flag_r, idle_r, ovr_r, nf_r, fe_r} <= 5'h00;
      end
      if (idle_hit) begin
        idle_r <= 1'b1;
      end
      if (rx_done) begin
        if (rx_buf_full_flag_r && !rx_clr) begin
          ovr_r <= 1'b1;
        end else begin
          rxbuf_r <= rx_sh_r[7:0];
          rx_buf_full_flag_r  <= 1'b1;
          nf_r    <= nacc_r | v_noise;
          fe_r    <= !v_bit;
          if (m_r) begin
            rx9_r <= rx_sh_r[8];
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_unmask_i && ((tx_buf_empty_flag_r && tie_r) || (tc_r && tx_done_irq_en_r)
               || ((rx_buf_full_flag_r || ovr_r) && rie_r) || (idle_r && idle_irq_en_r));
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_tx_idle_high: assert property ((tx_st == TX_IDLE) |=> tx_o && tx_oe_o)
    else $error("tx pin not high while idle");
  a_tx_off_release: assert property ((tx_st == TX_OFF) |=> !tx_oe_o)
    else $error("tx pin driven while disabled");
  a_break_low: assert property ((tx_st == TX_BRK) |=> !tx_o)
    else $error("break not low");
  a_pre_len: assert property ((tx_st == TX_OFF && txon_r) |=> tx_st == TX_PRE && tx_bits_r == frame_len)
    else $error("preamble length wrong");
  a_done_after_brk: assert property ((tx_st == TX_BRK && tx_last) |=> tc_r)
    else $error("done flag not set after break");
  a_empty_clear: assert property ((tx_clr && !(tx_st == TX_IDLE && txon_r && !sbk_r && hold_v_r)
                                   && !(tx_st == TX_SHIFT && tx_last)) |=> !tx_buf_empty_flag_r)
    else $error("empty flag not cleared");
  a_rx_fill: assert property ((rx_done && !rx_buf_full_flag_r) |=> rx_buf_full_flag_r && rxbuf_r == $past(rx_sh_r[7:0]))
    else $error("receive buffer not filled");
  a_overrun_keep: assert property ((rx_done && rx_buf_full_flag_r && !rx_clr) |=> ovr_r && $stable(rxbuf_r))
    else $error("overrun handling wrong");
  a_frame_err: assert property ((rx_done && !rx_buf_full_flag_r && !v_bit) |=> fe_r ##1 rx_st != RX_HUNT)
    else $error("framing flag missing");
endmodule
`default_nettype wire

// File: sim/ast_far_node.sv
// Remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_far_node (
  input  wire logic       clock_i,
  input  wire logic       line_i,
  input  wire logic       nine_i,
  output logic            rx_o,
  output logic            got_o,
  output logic [9:0]      word_o
);
  int         bt = 16;
  logic [9:0] w;
  initial begin
    rx_o = 1'b1;
    got_o = 1'b0;
    word_o = '0;
  end
  // Bits go LSB first; g names one bit that gets a one-clock glitch at mid-bit
  task automatic send(input logic [11:0] f, input int nb, input int g);
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < bt; j++) begin
        rx_o <= (i == g && j == bt / 2) ? ~f[i] : f[i];
        @(posedge clock_i);
      end
    end
    rx_o <= 1'b1;
  endtask
  // A break keeps the line low, so wait for it to go high before hunting again
  always begin
    wait (line_i === 1'b1);
    wait (line_i === 1'b0);
    repeat (bt / 2) @(posedge clock_i);
    for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
      repeat (bt) @(posedge clock_i);
      w[i] = line_i;
    end
    word_o <= nine_i ? {~w[9], w[8:0]} : {~w[8], 1'b0, w[7:0]};
    got_o <= 1'b1;
    @(posedge clock_i);
    got_o <= 1'b0;
  end
endmodule
`default_nettype wire

// File: sim/test_async_serial_transceiver.sv
// Self-checking bench of the async serial transceiver
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_transceiver;
  import ast_pkg::*;
  logic        clock_i = 1'b0;
  logic        nrst_i  = 1'b0;
  logic        hsel    = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = '0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = '0;
  logic        unmask  = 1'b0;
  logic        nine    = 1'b0;
  logic        rx, tx, tx_oe, irq, hrdy, hresp, got;
  logic [31:0] hrdata;
  logic [9:0]  got_w;
  logic [7:0]  rd_d, d, e;
  logic [9:0]  txq[$];
  logic [15:0] rq[$];
  int          err_count = 0;
  int          n_checks = 0;
  int          seed = 43;
  int          cnt;
  event        rd_ev;
  wire logic   line;
  assign line = tx_oe ? tx : 1'b1;
  always #2.5 clock_i = ~clock_i;
  ast_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .rx_i(rx), .irq_unmask_i(unmask), .tx_o(tx), .tx_oe_o(tx_oe),
    .irq_o(irq));
  ast_far_node i_far (.clock_i(clock_i), .line_i(line), .nine_i(nine), .rx_o(rx), .got_o(got), .word_o(got_w));
  task automatic chk(input string s, input logic [9:0] x, input logic [9:0] g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock_i); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do @(posedge clock_i); while (hrdy !== 1'b1);
    rd_d = hrdata[7:0];
    chk("hresp", 10'h000, {9'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus(a, 1'b1, v);
  endtask
  // Only the bits under the mask are compared; the rest may move on their own
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    bus(a, 1'b0, 8'h00);
    rq.push_back({x, m});
    ->rd_ev;
  endtask
  task automatic drain();
    while (txq.size() != 0) @(posedge clock_i);
    repeat (40) @(posedge clock_i);
  endtask
  task automatic fr(input logic [7:0] v, input int g);
    i_far.send({3'b111, v, 1'b0}, 10, g);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(rd_ev) begin
    logic [15:0] q;
    q = rq.pop_front();
    chk("register read", {2'h0, q[15:8] & q[7:0]}, {2'h0, rd_d & q[7:0]});
  end
  always @(posedge clock_i) begin
    if (got === 1'b1) begin
      if (txq.size() == 0) begin
        err_count++;
        $display("unexpected tx char exp none got %h", got_w);
      end else begin
        chk("tx char", txq.pop_front(), got_w);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(OFF_STATUS, STATUS_RST, 8'hFF);
    rd(8'h14, 8'h00, 8'hFF);
    rd(OFF_CTRL2, CTRL_RST, 8'hFF);
    wr(OFF_BAUD, BAUD_RST);
    wr(OFF_CTRL2, 8'h0C);
    d = 8'($random(seed));
    txq.push_back({2'b0, d});
    fork
      begin
        cnt = 0;
        while (tx !== 1'b0) begin
          @(posedge clock_i);
          cnt++;
        end
      end
      begin
        rd(OFF_STATUS, 8'hC0, 8'hC0);
        wr(OFF_DATA, d);
      end
    join
    chk("preamble", 10'h001, {9'h0, cnt >= 160 && cnt <= 175});
    drain();
    $display("test preamble done");
    rd(OFF_STATUS, 8'hC0, 8'hC0);
    d = 8'($random(seed));
    e = 8'($random(seed));
    txq.push_back({2'b0, d});
    txq.push_back({2'b0, e});
    wr(OFF_DATA, d);
    repeat (4) @(posedge clock_i);
    rd(OFF_STATUS, 8'h80, 8'hC0);
    wr(OFF_DATA, e);
    rd(OFF_STATUS, 8'h00, 8'hC0);
    drain();
    rd(OFF_STATUS, 8'hC0, 8'hC0);
    $display("test tx done");
    nine <= 1'b1;
    wr(OFF_CTRL1, 8'h50);
    d = 8'($random(seed));
    txq.push_back({2'b01, d});
    rd(OFF_STATUS, 8'h80, 8'h80);
    wr(OFF_DATA, d);
    drain();
    i_far.send({2'b11, 1'b1, d, 1'b0}, 11, -1);
    rd(OFF_STATUS, 8'h20, 8'h20);
    rd(OFF_CTRL1, 8'h80, 8'h80);
    rd(OFF_DATA, d, 8'hFF);
    rd(OFF_STATUS, 8'h00, 8'h20);
    wr(OFF_CTRL1, 8'h00);
    nine <= 1'b0;
    $display("test nine bit done");
    d = 8'($random(seed));
    e = 8'($random(seed));
    fr(d, -1);
    fr(e, -1);
    rd(OFF_STATUS, 8'h28, 8'h28);
    rd(OFF_DATA, d, 8'hFF);
    rd(OFF_STATUS, 8'h00, 8'h28);
    fr(d, 4);
    rd(OFF_STATUS, 8'h24, 8'h26);
    rd(OFF_DATA, d, 8'hFF);
    rd(OFF_STATUS, 8'h00, 8'h24);
    i_far.send(12'h800, 12, -1);
    rd(OFF_STATUS, 8'h22, 8'h22);
    rd(OFF_DATA, 8'h00, 8'hFF);
    $display("test rx errors done");
    unmask <= 1'b1;
    wr(OFF_CTRL2, 8'h1C);
    repeat (200) @(posedge clock_i);
    chk("irq", 10'h001, {9'h0, irq});
    unmask <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("irq masked", 10'h000, {9'h0, irq});
    rd(OFF_STATUS, 8'h10, 8'h10);
    rd(OFF_DATA, 8'h00, 8'hFF);
    rd(OFF_STATUS, 8'h00, 8'h10);
    $display("test idle done");
    txq.push_back(10'h200);
    wr(OFF_CTRL2, 8'h0D);
    repeat (400) @(posedge clock_i);
    wr(OFF_CTRL2, 8'h0C);
    drain();
    // The break in flight runs to its end before the trailing high bit
    repeat (160) @(posedge clock_i);
    chk("tx line", 10'h001, {9'h0, tx});
    rd(OFF_STATUS, 8'h40, 8'h40);
    unmask <= 1'b1;
    wr(OFF_CTRL2, 8'h4C);
    repeat (2) @(posedge clock_i);
    chk("irq done", 10'h001, {9'h0, irq});
    unmask <= 1'b0;
    wr(OFF_CTRL2, 8'h0C);
    $display("test break done");
    d = 8'($random(seed));
    e = 8'($random(seed));
    txq.push_back({2'b0, d});
    rd(OFF_STATUS, 8'hC0, 8'hC0);
    wr(OFF_DATA, d);
    rd(OFF_STATUS, 8'h00, 8'h40);
    wr(OFF_DATA, e);
    wr(OFF_CTRL2, 8'h04);
    wr(OFF_CTRL2, 8'h0C);
    drain();
    repeat (300) @(posedge clock_i);
    wr(OFF_CTRL2, 8'h00);
    repeat (4) @(posedge clock_i);
    chk("pin owned", 10'h000, {9'h0, tx_oe});
    $display("test toggle done");
    // Baud changes only while both directions are off
    wr(OFF_BAUD, 8'h49);
    i_far.bt = 96;
    wr(OFF_CTRL2, 8'h0C);
    d = 8'($random(seed));
    txq.push_back({2'b0, d});
    rd(OFF_STATUS, 8'h40, 8'h40);
    wr(OFF_DATA, d);
    // Receiver needs two slow ticks to reach the hunt state
    repeat (20) @(posedge clock_i);
    fr(d, -1);
    rd(OFF_STATUS, 8'h20, 8'h20);
    rd(OFF_DATA, d, 8'hFF);
    drain();
    $display("test baud done");
    wrap_up();
  end
endmodule
`default_nettype wire
